// file: hw/sfb_bus_if.sv
// pin front end of a serial flash: select, lanes, pause, modes, resets
// assumes spi clock and pins oversampled by a much faster system clock
//
// Overview of operation
// RL1 - select high: deselected, all lanes released
// RL2 - nothing accepted before first select falling edge
// RL3 - single lane: sample rising, drive falling
// RL4 - dual/quad: lanes bidirectional, same edge rules
// RL5 - quad only with quad enable; lanes 2,3
// RL6 - write protect low blocks status writes
// RL7 - pause begins with clock low
// RL8 - pause ends with clock low
// RL9 - pause: outputs released, inputs ignored, state kept
// RL10 - host keeps select low during pause
// RL11 - no pause when quad enable set
// RL12 - spi modes 0 and 3 supported
// RL13 - 3b/bb reads use two lanes
// RL14 - 6b/eb/e7/e3 reads use four lanes
// RL15 - 38h enters, ffh leaves four-wire command mode
// RL16 - four-wire mode: opcode in two clocks
// RL17 - power-up and soft reset: plain spi mode
// RL18 - power-up address width from strap bit
// RL19 - b7h/e9h set width, shown on status
// RL20 - 3-byte mode: extended register gives top bits
// RL21 - 66h then 99h: reset, busy 30 us
// RL22 - pin 3 selects pause or reset
// RL23 - reset input low: power-on state, priority
`timescale 1ns/1ps
module sfb_bus_if
    import sfb_pkg::*;
#(
    parameter int unsigned SW_RST_CYCLES = SFB_SW_RST_CYC
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic spi_clk,
    input wire logic cs_n,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic [3:0] io_oe,
    input wire logic reset_pin_n,
    input wire logic quad_io_enable_bit,
    input wire logic pin3_function_select,
    input wire logic powerup_addr_width_bit,
    input wire logic protect_cfg_bit,
    input wire logic [7:0] ext_addr_reg,
    input wire logic [7:0] tx_byte,
    output logic tx_take,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic addr_valid,
    output logic [31:0] addr_out,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic four_wire_command_mode,
    output logic current_addr_width_bit,
    output logic status_write_block,
    output logic device_resetting
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge finding

    logic [6:0] pin_s;
    logic [3:0] io_s;
    logic clk_s, cs_n_s, rstp_s;
    logic clk_d_r, cs_d_r;
    logic clk_rise, clk_fall, cs_fall;

    sfb_sync #(.W(7), .RST_VAL(SFB_PIN_RST)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({reset_pin_n, cs_n, spi_clk, io_i}),
        .q(pin_s)
    );

    assign io_s = pin_s[3:0];
    assign clk_s = pin_s[4];
    assign cs_n_s = pin_s[5];
    assign rstp_s = pin_s[6];
    // RL12 either idle level
    assign clk_rise = clk_s & ~clk_d_r;
    assign clk_fall = ~clk_s & clk_d_r;
    assign cs_fall = ~cs_n_s & cs_d_r;

    ////////////////////////////////////////////////////////////////////////
    // pause, resets, qualification

    sfb_state_t state_r, state_nxt;
    logic [12:0] rcnt_r;
    logic armed_r, pause_r, qpi_r, addr4_r, rst_arm_r;
    logic pause_en, pause_nxt, hw_rst, active, rise_ev, fall_ev;

    // RL11 pause on pin 3
    assign pause_en = ~quad_io_enable_bit & ~pin3_function_select & ~cs_n_s;
    // RL22 pin 3 reset
    assign hw_rst = ~rstp_s |
        (~quad_io_enable_bit & pin3_function_select & ~io_s[3]);
    // RL7 RL8 pause follows pin while clock low
    assign pause_nxt = pause_en & (clk_s ? pause_r : ~io_s[3]);
    // RL9 edges ignored while paused
    assign active = ~cs_n_s & armed_r & ~pause_r & ~hw_rst;
    assign rise_ev = clk_rise & active;
    assign fall_ev = clk_fall & active;

    ////////////////////////////////////////////////////////////////////////
    // input shifter

    logic st_idle, st_opc, st_addr, st_data, st_rst;
    logic [2:0] in_ln, addr_ln_r, data_ln_r;
    logic [31:0] sh_r, sh_nxt;
    logic [5:0] cnt_r, cnt_inc, ph_len;
    logic dout_r, shifting, ph_done;

    assign st_idle = state_r == SFB_ST_IDLE;
    assign st_opc = state_r == SFB_ST_OPC;
    assign st_addr = state_r == SFB_ST_ADDR;
    assign st_data = state_r == SFB_ST_DATA;
    assign st_rst = state_r == SFB_ST_RST;
    // RL16 four lanes for opcode
    assign in_ln = st_opc ? (qpi_r ? SFB_LN4 : SFB_LN1) :
        (st_addr ? addr_ln_r : data_ln_r);
    // RL3 RL4 sample on rising
    assign sh_nxt = (in_ln == SFB_LN4) ? {sh_r[27:0], io_s} :
        (in_ln == SFB_LN2) ? {sh_r[29:0], io_s[1:0]} : {sh_r[30:0], io_s[0]};
    assign cnt_inc = cnt_r + {3'h0, in_ln};
    assign ph_len = st_opc ? SFB_OPC_BITS : st_addr ?
        (addr4_r ? SFB_A4_BITS : SFB_A3_BITS) : SFB_BYTE_BITS;
    assign shifting = rise_ev & (st_opc | st_addr | (st_data & ~dout_r));
    assign ph_done = shifting & (cnt_inc == ph_len);

    ////////////////////////////////////////////////////////////////////////
    // opcode decode

    logic [7:0] opc;
    logic op_act, op_dual, op_quad, op_rd_ok, op_ctl, sw_go;
    logic [2:0] nx_addr_ln, nx_data_ln;

    assign opc = sh_nxt[7:0];
    assign op_act = ph_done & st_opc;
    // RL13 dual reads
    assign op_dual = (opc == SFB_OP_RD_DO) | (opc == SFB_OP_RD_DIO);
    assign op_quad = (opc == SFB_OP_RD_QO) | (opc == SFB_OP_RD_QIO) |
        (opc == SFB_OP_RD_QW) | (opc == SFB_OP_RD_QOW);
    // RL5 RL14 quad reads need quad enable
    assign op_rd_ok = op_dual | (op_quad & quad_io_enable_bit);
    assign op_ctl = (opc == SFB_OP_RST_EN) | (opc == SFB_OP_RST) |
        (opc == SFB_OP_QPI_ON) | (opc == SFB_OP_QPI_OFF) |
        (opc == SFB_OP_A4_ON) | (opc == SFB_OP_A4_OFF);
    // RL21 enable then reset, back to back
    assign sw_go = op_act & (opc == SFB_OP_RST) & rst_arm_r;
    assign nx_addr_ln = qpi_r ? SFB_LN4 : (opc == SFB_OP_RD_DIO) ? SFB_LN2 :
        (op_quad & (opc != SFB_OP_RD_QO)) ? SFB_LN4 : SFB_LN1;
    assign nx_data_ln = qpi_r ? SFB_LN4 : op_dual ? SFB_LN2 :
        op_quad ? SFB_LN4 : SFB_LN1;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SFB_ST_IDLE:
                if (cs_fall)
                    state_nxt = SFB_ST_OPC;
            SFB_ST_OPC:
                if (ph_done)
                    state_nxt = sw_go ? SFB_ST_RST : op_rd_ok ? SFB_ST_ADDR :
                        (op_ctl | op_quad) ? SFB_ST_IDLE : SFB_ST_DATA;
            SFB_ST_ADDR:
                if (ph_done)
                    state_nxt = SFB_ST_DATA;
            SFB_ST_DATA:
                state_nxt = SFB_ST_DATA;
            SFB_ST_RST:
                if (rcnt_r == 13'h0000)
                    state_nxt = SFB_ST_IDLE;
            default:
                state_nxt = SFB_ST_IDLE;
        endcase
        // RL10 select high drops the instruction
        if (cs_n_s & ~st_rst)
            state_nxt = SFB_ST_IDLE;
        // RL23 reset input wins over all
        if (hw_rst)
            state_nxt = SFB_ST_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // mode flags

    logic pwr_rst, qpi_nxt, addr4_nxt, rst_arm_nxt, armed_nxt;

    assign pwr_rst = hw_rst | sw_go;
    // RL15 RL17 four-wire mode entry and exit
    assign qpi_nxt = pwr_rst ? SFB_QPI_RST :
        (op_act & (opc == SFB_OP_QPI_ON) & quad_io_enable_bit) ? 1'b1 :
        (op_act & (opc == SFB_OP_QPI_OFF)) ? 1'b0 : qpi_r;
    // RL18 RL19 address width
    assign addr4_nxt = pwr_rst ? powerup_addr_width_bit :
        (op_act & (opc == SFB_OP_A4_ON)) ? 1'b1 :
        (op_act & (opc == SFB_OP_A4_OFF)) ? 1'b0 : addr4_r;
    assign rst_arm_nxt = pwr_rst ? 1'b0 :
        op_act ? (opc == SFB_OP_RST_EN) : rst_arm_r;
    // RL2 arm on select falling edge
    assign armed_nxt = pwr_rst ? 1'b0 : cs_fall ? 1'b1 : armed_r;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_r <= SFB_ST_IDLE;
            clk_d_r <= 1'b1;
            cs_d_r <= 1'b1;
            armed_r <= 1'b0;
            pause_r <= 1'b0;
            qpi_r <= SFB_QPI_RST;
            addr4_r <= powerup_addr_width_bit;
            rst_arm_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            clk_d_r <= clk_s;
            cs_d_r <= cs_n_s;
            armed_r <= armed_nxt;
            pause_r <= pause_nxt;
            qpi_r <= qpi_nxt;
            addr4_r <= addr4_nxt;
            rst_arm_r <= rst_arm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output shifter

    logic [2:0] ocnt_r;
    logic [7:0] tx_sh_r, tx_cur;
    logic out_go;
    logic [3:0] oe_mask, oe_nxt, io_nxt;

    // RL3 RL4 drive on falling
    assign out_go = fall_ev & st_data & dout_r;
    assign tx_cur = (ocnt_r == 3'h0) ? tx_byte : tx_sh_r;
    assign oe_mask = (data_ln_r == SFB_LN4) ? 4'hf :
        (data_ln_r == SFB_LN2) ? 4'h3 : 4'h2;
    // RL1 RL9 lanes released when deselected or paused
    assign oe_nxt = (st_data & dout_r & ~cs_n_s & ~pause_nxt & ~hw_rst) ?
        oe_mask : 4'h0;
    assign io_nxt = (data_ln_r == SFB_LN4) ? tx_cur[7:4] :
        (data_ln_r == SFB_LN2) ? {2'b00, tx_cur[7:6]} :
        {2'b00, tx_cur[7], 1'b0};

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sh_r <= 32'h00000000;
            cnt_r <= 6'h00;
            addr_ln_r <= SFB_LN1;
            data_ln_r <= SFB_LN1;
            dout_r <= 1'b0;
            ocnt_r <= 3'h0;
            tx_sh_r <= 8'h00;
            rcnt_r <= 13'h0000;
        end
        else
        begin
            sh_r <= shifting ? sh_nxt : sh_r;
            cnt_r <= (ph_done | st_idle | st_rst) ? 6'h00 :
                shifting ? cnt_inc : cnt_r;
            addr_ln_r <= op_act ? nx_addr_ln : addr_ln_r;
            data_ln_r <= op_act ? nx_data_ln : data_ln_r;
            dout_r <= op_act ? 1'b0 : (ph_done & st_addr) ? 1'b1 : dout_r;
            ocnt_r <= ~st_data ? 3'h0 : out_go ? ocnt_r + data_ln_r : ocnt_r;
            tx_sh_r <= out_go ? 8'(tx_cur << data_ln_r) : tx_sh_r;
            // RL21 busy count
            rcnt_r <= sw_go ? 13'(SW_RST_CYCLES - 1) :
                (st_rst & (rcnt_r != 13'h0000)) ? rcnt_r - 13'h0001 : rcnt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            io_o <= 4'h0;
            io_oe <= 4'h0;
            tx_take <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_opcode <= 8'h00;
            addr_valid <= 1'b0;
            addr_out <= 32'h00000000;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
            status_write_block <= 1'b0;
            device_resetting <= 1'b0;
        end
        else
        begin
            io_o <= out_go ? io_nxt : io_o;
            io_oe <= oe_nxt;
            tx_take <= out_go & (ocnt_r == 3'h0);
            cmd_valid <= op_act;
            cmd_opcode <= op_act ? opc : cmd_opcode;
            addr_valid <= ph_done & st_addr;
            // RL20 extended register on top
            addr_out <= ~(ph_done & st_addr) ? addr_out :
                addr4_r ? sh_nxt : {ext_addr_reg, sh_nxt[23:0]};
            rx_valid <= ph_done & st_data;
            rx_byte <= (ph_done & st_data) ? sh_nxt[7:0] : rx_byte;
            // RL6 protect pin unused in quad
            status_write_block <= ~quad_io_enable_bit & ~io_s[2] &
                protect_cfg_bit;
            device_resetting <= hw_rst | (state_nxt == SFB_ST_RST);
        end
    end

    assign four_wire_command_mode = qpi_r;
    assign current_addr_width_bit = addr4_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_swrst_start;
        $rose(state_r == SFB_ST_RST);
    endsequence

    a_desel_hiz: assert property (cs_n_s |=> io_oe == 4'h0) // RL1
        else $error("lanes driven while deselected");
    a_unarmed_quiet: assert property (!armed_r |=> !cmd_valid) // RL2
        else $error("opcode taken before select edge");
    a_pause_hiz: assert property (pause_nxt |=> io_oe == 4'h0) // RL9
        else $error("lanes driven during pause");
    a_pause_quad: assert property (quad_io_enable_bit |=> !pause_r) // RL11
        else $error("pause active with quad enable");
    a_qpi_needs_qe: assert property ($rose(qpi_r) |-> // RL15
        $past(quad_io_enable_bit) && cmd_opcode == SFB_OP_QPI_ON)
        else $error("four-wire mode without quad enable");
    a_swrst_busy: assert property (s_swrst_start |-> // RL21
        (st_rst && device_resetting && !qpi_r)[*8])
        else $error("soft reset busy window broken");
    a_wp_block: assert property ((!quad_io_enable_bit && !io_s[2] && // RL6
        protect_cfg_bit) |=> status_write_block)
        else $error("status write not blocked");
    a_hwrst_prio: assert property (!rstp_s |=> // RL23
        st_idle && !armed_r && !cmd_valid && device_resetting)
        else $error("reset input not obeyed");
    a_addr_width: assert property (cmd_valid && // RL19
        cmd_opcode == SFB_OP_A4_ON |-> current_addr_width_bit)
        else $error("width not set by b7h");
    a_out_on_fall: assert property ($changed(io_o) |-> // RL3
        $past(clk_fall) && $past(st_data))
        else $error("output changed off falling edge");

endmodule

// file: pkg/sfb_pkg.sv
// constants, opcodes and state codes of the serial flash bus front end
// assumes a 250 MHz system clock sampling all pins
package sfb_pkg;

    localparam int unsigned SFB_CLK_PERIOD_PS = 4000;
    // software reset recovery time, ns
    localparam int unsigned SFB_SW_RST_TIME_NS = 30000;
    localparam int unsigned SFB_SW_RST_CYC =
        (SFB_SW_RST_TIME_NS * 1000 + SFB_CLK_PERIOD_PS - 1) /
        SFB_CLK_PERIOD_PS;

    localparam logic [7:0] SFB_OP_RST_EN = 8'h66;
    localparam logic [7:0] SFB_OP_RST = 8'h99;
    localparam logic [7:0] SFB_OP_QPI_ON = 8'h38;
    localparam logic [7:0] SFB_OP_QPI_OFF = 8'hff;
    localparam logic [7:0] SFB_OP_A4_ON = 8'hb7;
    localparam logic [7:0] SFB_OP_A4_OFF = 8'he9;
    localparam logic [7:0] SFB_OP_RD_DO = 8'h3b;
    localparam logic [7:0] SFB_OP_RD_DIO = 8'hbb;
    localparam logic [7:0] SFB_OP_RD_QO = 8'h6b;
    localparam logic [7:0] SFB_OP_RD_QIO = 8'heb;
    localparam logic [7:0] SFB_OP_RD_QW = 8'he7;
    localparam logic [7:0] SFB_OP_RD_QOW = 8'he3;

    localparam logic [5:0] SFB_OPC_BITS = 6'h08;
    localparam logic [5:0] SFB_BYTE_BITS = 6'h08;
    localparam logic [5:0] SFB_A3_BITS = 6'h18;
    localparam logic [5:0] SFB_A4_BITS = 6'h20;

    localparam logic [2:0] SFB_LN1 = 3'h1;
    localparam logic [2:0] SFB_LN2 = 3'h2;
    localparam logic [2:0] SFB_LN4 = 3'h4;

    // pins after reset: reset pin high, select high, clock high, io high
    localparam logic [6:0] SFB_PIN_RST = 7'h7f;
    localparam logic SFB_QPI_RST = 1'b0;

    typedef enum logic [4:0] {
        SFB_ST_IDLE = 5'b00001,
        SFB_ST_OPC = 5'b00010,
        SFB_ST_ADDR = 5'b00100,
        SFB_ST_DATA = 5'b01000,
        SFB_ST_RST = 5'b10000
    } sfb_state_t;

endpackage

// file: hw/sfb_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clock
`timescale 1ns/1ps
module sfb_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

// file: tb/sfb_host.sv
// spi host model: select, serial clock and the four lanes
// assumes the bench clock only paces the start of each frame and the changing value on released lanes
`timescale 1ns/1ps
module sfb_host (
    input wire logic clock,
    input wire logic [3:0] io_oe,
    input wire logic [3:0] io_o,
    output logic spi_clk,
    output logic cs_n,
    output logic [3:0] io_i
);
    logic [3:0] h_oe;
    logic [3:0] h_d;
    logic [3:0] keep_r;
    logic [1:0] pv;
    logic m3;
    // released lanes carry a value that keeps changing
    assign io_i = (io_oe & io_o) | (~io_oe & h_oe & h_d)
        | (~io_oe & ~h_oe & ~keep_r);
    always @(posedge clock)
    begin
        keep_r <= io_i;
    end
    initial
    begin
        spi_clk = 1'b0;
        cs_n = 1'b1;
        h_oe = 4'hd;
        h_d = 4'hf;
        pv = 2'h3;
        m3 = 1'b0;
        keep_r = 4'h0;
    end
    ////////////////////////////////////////////////////////////////
    // lane 2 is write protect, lane 3 pause or reset
    task automatic pins(input logic wp, input logic hd);
        pv = {hd, wp};
        h_d[3:2] = pv;
    endtask
    // idle level set, then select falls
    task automatic start(input logic m);
        @(posedge clock);
        #1;
        m3 = m;
        spi_clk = m;
        h_oe = 4'hd;
        #80;
        cs_n = 1'b0;
        #80;
    endtask
    task automatic stop();
        spi_clk = m3;
        #80;
        cs_n = 1'b1;
        h_oe = 4'hd;
        h_d = {pv, 2'h3};
        #80;
    endtask
    // launch on falling edge, msb first
    task automatic send(input logic [31:0] v, input int n, input int w);
        logic [3:0] c;
        int i;
        for (i = n; i > 0; i = i - w)
        begin
            c = 4'(v >> (i - w));
            spi_clk = 1'b0;
            h_oe = (w == 1) ? 4'hd : 4'hf;
            h_d = (w == 4) ? c : {pv, c[1:0]};
            #80;
            spi_clk = 1'b1;
            #80;
        end
    endtask
    task automatic recv(input int w, output logic [7:0] b,
        output logic [3:0] oe);
        int i;
        h_oe = (w == 4) ? 4'h0 : 4'hc;
        h_d = {pv, 2'h0};
        for (i = 0; i < 8; i = i + w)
        begin
            spi_clk = 1'b0;
            #80;
            b = (w == 4) ? {b[3:0], io_i} : {b[5:0], io_i[1:0]};
            oe = io_oe;
            spi_clk = 1'b1;
            #80;
        end
    endtask
    // pause with clock low, select held
    task automatic hold_run();
        spi_clk = 1'b0;
        #80;
        pins(pv[0], 1'b0);
        #80;
        repeat (3)
        begin
            h_d[0] = ~h_d[0];
            spi_clk = 1'b1;
            #80;
            spi_clk = 1'b0;
            #80;
        end
        pins(pv[0], 1'b1);
        #80;
    endtask
endmodule

// file: tb/tb.sv
// self-checking bench of the flash bus front end
// assumes the host model in sfb_host and a 250 MHz clock
`timescale 1ns/1ps
module tb
    import sfb_pkg::*;
;
    localparam int RC = 64;
    localparam logic [7:0] QOP [4] = '{8'h6b, 8'heb, 8'he7, 8'he3};
    logic clock, rst_n, rpn, quad, p3s, paw, prot;
    logic [7:0] ext, txb, rx_byte, cop, last_rx;
    logic [31:0] addr_out;
    logic [3:0] io_i, io_o, io_oe;
    logic spi_clk, cs_n, tx_take, cmd_valid, addr_valid, rx_valid;
    logic fwm, caw, swb, dres;
    int n_errors, num_checks, n_cmd, rcnt, r0, n_take, n_adv;

    sfb_bus_if #(.SW_RST_CYCLES(RC)) sfb_bus_if_i (
        .clock(clock), .rst_n(rst_n), .spi_clk(spi_clk), .cs_n(cs_n),
        .io_i(io_i), .io_o(io_o), .io_oe(io_oe), .reset_pin_n(rpn),
        .quad_io_enable_bit(quad), .pin3_function_select(p3s),
        .powerup_addr_width_bit(paw), .protect_cfg_bit(prot),
        .ext_addr_reg(ext), .tx_byte(txb), .tx_take(tx_take),
        .cmd_valid(cmd_valid), .cmd_opcode(cop), .addr_valid(addr_valid),
        .addr_out(addr_out), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .four_wire_command_mode(fwm), .current_addr_width_bit(caw),
        .status_write_block(swb), .device_resetting(dres));
    sfb_host host_i (.clock(clock), .io_oe(io_oe), .io_o(io_o),
        .spi_clk(spi_clk), .cs_n(cs_n), .io_i(io_i));

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock)
    begin
        if (cmd_valid === 1'b1)
            n_cmd <= n_cmd + 1;
        if (rx_valid === 1'b1)
            last_rx <= rx_byte;
        if (dres === 1'b1)
            rcnt <= rcnt + 1;
        if (tx_take === 1'b1)
            n_take <= n_take + 1;
        if (addr_valid === 1'b1)
            n_adv <= n_adv + 1;
    end
    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic op(input logic [7:0] v, input int w);
        host_i.start(1'b0);
        host_i.send(32'(v), 8, w);
        host_i.stop();
    endtask
    task automatic rd(input logic [7:0] v, input logic [31:0] a,
        input int n, input int aw, input int dw, input logic [3:0] oe_e,
        input logic [31:0] ea);
        logic [7:0] b;
        logic [3:0] oe;
        int t0;
        int a0;
        t0 = n_take;
        a0 = n_adv;
        host_i.start(1'b0);
        host_i.send(32'(v), 8, 1);
        host_i.send(a, n, aw);
        host_i.recv(dw, b, oe);
        chk("lane enables", 32'(oe_e), 32'(oe)); // lanes
        chk("addr strobes", (oe_e != 4'h0) ? 1 : 0, n_adv - a0);
        chk("byte takes", (oe_e != 4'h0) ? 1 : 0, n_take - t0);
        if (oe_e != 4'h0)
        begin
            chk("address", ea, addr_out); // upper byte
            chk("read data", 32'(txb), 32'(b)); // falling edge out
        end
        host_i.stop();
        chk("lanes idle", 32'h0, 32'(io_oe)); // released
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        n_errors = 0;
        num_checks = 0;
        n_cmd = 0;
        rcnt = 0;
        n_take = 0;
        n_adv = 0;
        last_rx = 8'h00;
        rst_n = 1'b0;
        rpn = 1'b1;
        quad = 1'b0;
        p3s = 1'b0;
        paw = 1'b1;
        prot = 1'b1;
        ext = 8'h5a;
        txb = 8'hc6;
        wt(10);
        rst_n = 1'b1;
        wt(4);
        chk("lanes", 32'h0, 32'(io_oe)); // released
        chk("four wire", 32'h0, 32'(fwm)); // spi mode
        chk("width", 32'h1, 32'(caw)); // from strap
        op(SFB_OP_A4_OFF, 1);
        chk("width", 32'h0, 32'(caw)); // three bytes
        rd(SFB_OP_RD_DIO, 32'habcdef, 24, 2, 2, 4'h3, 32'h5aabcdef);
        op(SFB_OP_A4_ON, 1);
        chk("width", 32'h1, 32'(caw)); // four bytes
        rd(SFB_OP_RD_DO, 32'h12345678, 32, 1, 2, 4'h3, 32'h12345678);
        rd(SFB_OP_RD_QO, 32'h0, 32, 1, 4, 4'h0, 32'h0); // refused
        quad = 1'b1;
        for (int k = 0; k < 4; k++)
            rd(QOP[k], 32'h89abcdef, 32, (k == 0) ? 1 : 4, 4, 4'hf,
                32'h89abcdef); // four lanes
        host_i.pins(1'b0, 1'b1);
        wt(4);
        chk("wp block", 32'h0, 32'(swb)); // lost in quad
        quad = 1'b0;
        wt(4);
        chk("wp block", 32'h1, 32'(swb)); // blocks writes
        prot = 1'b0;
        wt(4);
        chk("wp block", 32'h0, 32'(swb)); // needs config
        prot = 1'b1;
        host_i.pins(1'b1, 1'b1);
        host_i.start(1'b1);
        host_i.send(32'h0, 4, 1);
        host_i.hold_run();
        host_i.send(32'h2, 4, 1);
        host_i.send(32'ha5, 8, 1);
        host_i.stop();
        chk("opcode", 32'h02, 32'(cop)); // resumed
        chk("rx byte", 32'ha5, 32'(last_rx)); // mode three
        quad = 1'b1;
        host_i.pins(1'b1, 1'b0);
        op(8'h06, 1);
        chk("opcode", 32'h06, 32'(cop)); // lane not pause
        host_i.pins(1'b1, 1'b1);
        quad = 1'b0;
        op(SFB_OP_QPI_ON, 1);
        chk("four wire", 32'h0, 32'(fwm)); // needs quad
        quad = 1'b1;
        op(SFB_OP_QPI_ON, 1);
        chk("four wire", 32'h1, 32'(fwm)); // entered
        op(SFB_OP_QPI_OFF, 4);
        chk("four wire", 32'h0, 32'(fwm)); // two clocks
        op(SFB_OP_QPI_ON, 1);
        op(SFB_OP_RST_EN, 4);
        r0 = rcnt;
        host_i.start(1'b0);
        host_i.send(32'(SFB_OP_RST), 8, 4);
        chk("resetting", 32'h1, 32'(dres)); // busy
        host_i.stop();
        wt(RC);
        chk("reset span", RC, rcnt - r0); // length
        chk("four wire", 32'h0, 32'(fwm)); // back to spi
        op(SFB_OP_RST_EN, 1);
        op(8'h06, 1);
        r0 = rcnt;
        op(SFB_OP_RST, 1);
        chk("reset span", 32'h0, rcnt - r0); // cancelled
        op(SFB_OP_QPI_ON, 1);
        host_i.start(1'b0);
        host_i.send(32'h0, 4, 1);
        rpn = 1'b0;
        wt(5);
        chk("resetting", 32'h1, 32'(dres)); // pin reset
        chk("four wire", 32'h0, 32'(fwm)); // power-on state
        rpn = 1'b1;
        wt(5);
        r0 = n_cmd;
        host_i.send(32'h06, 8, 1);
        host_i.stop();
        chk("commands", 32'h0, n_cmd - r0); // new select needed
        quad = 1'b0;
        p3s = 1'b1;
        host_i.pins(1'b1, 1'b0);
        wt(5);
        chk("resetting", 32'h1, 32'(dres)); // lane three reset
        quad = 1'b1;
        wt(5);
        chk("resetting", 32'h0, 32'(dres)); // off in quad
        host_i.pins(1'b1, 1'b1);
        p3s = 1'b0;
        paw = 1'b0;
        rst_n = 1'b0;
        wt(2);
        rst_n = 1'b1;
        wt(2);
        chk("width", 32'h0, 32'(caw)); // strap low
        stop_test();
    end
    initial
    begin
        #300000;
        n_errors = n_errors + 1;
        stop_test();
    end
endmodule
